// ---- lba_defines.svh ----
// register offsets, field positions, reset values and limits of the line buffer unit
// assumes inclusion by bare name from every design file that needs a constant
//
// Contract
// RULE1 - aging counter advances once every N clocks, N programmable 1 to 255.
// RULE2 - aging counter has four states; line timestamps are two-bit Gray values.
// RULE3 - a line is stale once the counter is two steps past its stamp.
// RULE4 - allocation or any serving access copies the counter into the line stamp.
// RULE5 - shared read hits, writes to write or modified lines, reallocation refresh stamps.
// RULE6 - stale lines are flushed or invalidated without any CPU request.
// RULE7 - stale shared lines become invalid; stale dirty lines are written back.
// RULE8 - lines freed by aging are preferred over all others for allocation.
// RULE9 - lines are also flushed on sleep entry and on the sideband flush request.
// RULE10 - with no free buffer, a chosen line is flushed or invalidated early.
// RULE11 - each line has an LRU counter cleared by any access to it.
// RULE12 - a line's LRU counter increments when another line sees an event.
// RULE13 - victim choice uses both LRU counters and line states.
// RULE14 - separate outbound FIFOs carry addresses and write data; depth is a parameter.
// RULE15 - separate inbound FIFOs carry read data and write responses; depth is a parameter.
// RULE16 - the outbound FIFO path is the crossing toward the AXI domain.
// RULE17 - transactions go in order; address push never trails its write-data push.
// RULE18 - a line flush is taken at once unless the outbound FIFO is full.
// RULE19 - flush writes back dirty lines, W to I, M to S; invalidate takes S to I.
// RULE20 - a barrier is a flush followed by an invalidate, leaving all lines invalid.
// RULE21 - software issues flush or invalidate before sharing memory with other bus masters.
// RULE22 - each line buffer holds 128 bits as four 32-bit words.
// RULE23 - every line is always modified, write, shared or invalid.
// RULE24 - an invalid line is always chosen first for allocation.
// RULE25 - flush aggressiveness 0 allows two dirty lines, 1 allows three.
// RULE26 - age comparison is modulo four so counter wrap is handled.
// RULE27 - number of lines is a parameter, each line has its own enable.
`ifndef LBA_DEFINES_SVH
`define LBA_DEFINES_SVH

`define LBA_OFF_CTRL       8'h00
`define LBA_OFF_CMD        8'h04
`define LBA_OFF_STATUS     8'h08

`define LBA_CTRL_FLVL_BIT  8
`define LBA_CTRL_EN_LSB    16
`define LBA_PERIOD_RST     8'h10
`define LBA_FLVL_RST       1'b0

`define LBA_CMD_FLUSH_BIT  0
`define LBA_CMD_INV_BIT    1

`define LBA_STAT_AC_LSB    16
`define LBA_STAT_FP_BIT    18
`define LBA_STAT_IP_BIT    19
`define LBA_STAT_BUSY_BIT  20
`define LBA_STAT_BR_LSB    21

`define LBA_AGE_LIMIT      2'd2
`define LBA_WB_LIMIT0      4'd2
`define LBA_WB_LIMIT1      4'd3

`define LBA_RESP_OKAY      2'b00
`define LBA_RESP_SLVERR    2'b10

`endif

// ---- lba_pkg.sv ----
// types shared by the line buffer unit
// assumes nothing of its surroundings
package lba_pkg;

	typedef enum logic [1:0] {
		LS_INVALID  = 2'b00,
		LS_SHARED   = 2'b01,
		LS_WRITE    = 2'b10,
		LS_MODIFIED = 2'b11
	} lba_line_state_t;

	typedef enum logic [2:0] {
		FS_IDLE    = 3'b000,
		FS_RD_REQ  = 3'b001,
		FS_RD_WAIT = 3'b011,
		FS_WB      = 3'b100
	} lba_fsm_t;

endpackage

// ---- lba_stream_if.sv ----
// valid/ready stream carrier between the unit and its FIFOs
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface lba_stream_if #(
	parameter int W = 32
);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ---- lba_fifo.sv ----
// small FIFO with registered output stage and registered ready
// assumes synchronous active-low reset on aclk
`timescale 1ns/100ps
module lba_fifo #(
	parameter int W     = 32,
	parameter int DEPTH = 2
) (
	input wire logic aclk,
	input wire logic aresetn,
	lba_stream_if.snk push_s,
	lba_stream_if.src pop_s
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [W-1:0]  mem [DEPTH];
	logic [PW-1:0] wp;
	logic [PW-1:0] rp;
	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;
	logic          in_rdy;
	logic          o_vld;
	logic [W-1:0]  o_dat;
	wire           push;
	wire           pop;

	assign push         = push_s.valid && in_rdy;
	assign pop          = (cnt != '0) && (!o_vld || pop_s.ready);
	assign next_cnt     = cnt + CW'(push) - CW'(pop);
	assign push_s.ready = in_rdy;
	assign pop_s.valid  = o_vld;
	assign pop_s.data   = o_dat;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wp     <= '0;
			rp     <= '0;
			cnt    <= '0;
			in_rdy <= 1'b1;
			o_vld  <= 1'b0;
			o_dat  <= '0;
		end else begin
			if (push) begin
				mem[wp] <= push_s.data;
				wp      <= (wp == PW'(DEPTH - 1)) ? '0 : wp + 1'b1;
			end
			if (pop) begin
				o_dat <= mem[rp];
				rp    <= (rp == PW'(DEPTH - 1)) ? '0 : rp + 1'b1;
			end
			o_vld  <= pop || (o_vld && !pop_s.ready);
			cnt    <= next_cnt;
			in_rdy <= next_cnt < CW'(DEPTH);
		end
	end
endmodule

// ---- lba_data_line_buffer_unit.sv ----
// line buffer write-buffer/read-cache with aging, LRU victims and AXI-side FIFOs
// assumes cpu and AXI streams synchronous to aclk; registers reached over AXI4-Lite
`timescale 1ns/100ps
`include "lba_defines.svh"
module lba_data_line_buffer_unit import lba_pkg::*; #(
	parameter int NUM_LINES = 4,
	parameter int OUT_DEPTH = 4,
	parameter int IN_DEPTH  = 2,
	parameter int LRU_W     = 3
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [7:0]   s_awaddr,
	input  wire logic         s_awvalid,
	output logic              s_awready,
	input  wire logic [31:0]  s_wdata,
	input  wire logic [3:0]   s_wstrb,
	input  wire logic         s_wvalid,
	output logic              s_wready,
	output logic [1:0]        s_bresp,
	output logic              s_bvalid,
	input  wire logic         s_bready,
	input  wire logic [7:0]   s_araddr,
	input  wire logic         s_arvalid,
	output logic              s_arready,
	output logic [31:0]       s_rdata,
	output logic [1:0]        s_rresp,
	output logic              s_rvalid,
	input  wire logic         s_rready,
	input  wire logic         cpu_valid,
	input  wire logic         cpu_write,
	input  wire logic [31:0]  cpu_addr,
	input  wire logic [31:0]  cpu_wdata,
	input  wire logic [3:0]   cpu_wstrb,
	output logic              cpu_ready,
	output logic [31:0]       cpu_rdata,
	input  wire logic         sleep_entry,
	input  wire logic         sideband_flush,
	output logic              m_addr_valid,
	input  wire logic         m_addr_ready,
	output logic              m_addr_write,
	output logic [31:0]       m_addr,
	output logic              m_wdat_valid,
	input  wire logic         m_wdat_ready,
	output logic [127:0]      m_wdat,
	output logic [15:0]       m_wstb,
	input  wire logic         s_rdat_valid,
	output logic              s_rdat_ready,
	input  wire logic [127:0] s_rdat,
	input  wire logic         s_bres_valid,
	output logic              s_bres_ready,
	input  wire logic [1:0]   s_bres
);
	localparam int IW = (NUM_LINES > 1) ? $clog2(NUM_LINES) : 1;
	localparam int SW = LRU_W + 4;

	lba_line_state_t  st    [NUM_LINES];  // RULE23
	logic [27:0]      tag   [NUM_LINES];
	logic [127:0]     ldat  [NUM_LINES];  // RULE22
	logic [15:0]      lbe   [NUM_LINES];
	logic [1:0]       stamp [NUM_LINES];
	logic [LRU_W-1:0] lru   [NUM_LINES];
	logic [SW-1:0]    score [NUM_LINES];
	logic [NUM_LINES-1:0] hit;
	logic [NUM_LINES-1:0] expd;
	logic [NUM_LINES-1:0] dirty;

	lba_fsm_t             fsm;
	logic [IW-1:0]        cur;
	logic [7:0]           period_cfg;
	logic                 flvl;
	logic [NUM_LINES-1:0] line_en;
	logic                 flush_pend;
	logic                 inv_pend;
	logic [1:0]           ac_bin;
	logic [7:0]           ac_div;
	logic [1:0]           last_bresp;
	logic [7:0]           aw_q;
	logic [31:0]          w_q;
	logic [3:0]           ws_q;

	logic                 hit_any;
	logic [IW-1:0]        hit_idx;
	logic [IW-1:0]        vic_idx;
	logic [SW-1:0]        best;
	logic                 fl_any;
	logic [IW-1:0]        fl_idx;
	logic                 ex_any;
	logic [IW-1:0]        ex_idx;
	logic [IW-1:0]        lvl_idx;
	logic [LRU_W:0]       lvl_best;
	logic [3:0]           dirty_cnt;
	logic                 inv_avail;
	logic                 shared_any;
	logic [15:0]          st_vec;
	logic [127:0]         mg_data;
	logic [15:0]          mg_be;
	logic [127:0]         fill_data;

	lba_stream_if #(.W(33))  addr_in ();
	lba_stream_if #(.W(33))  addr_out ();
	lba_stream_if #(.W(144)) wdat_in ();
	lba_stream_if #(.W(144)) wdat_out ();
	lba_stream_if #(.W(128)) rd_in ();
	lba_stream_if #(.W(128)) rd_out ();
	lba_stream_if #(.W(2))   br_in ();
	lba_stream_if #(.W(2))   br_out ();

	// aging counter: binary inside, Gray when stamped
	wire [7:0] period_m1 = (period_cfg == 8'h00) ? 8'h00 : period_cfg - 8'h01;
	wire       ac_tick   = ac_div >= period_m1;
	wire [1:0] ac_gray   = ac_bin ^ {1'b0, ac_bin[1]};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ac_div <= 8'h00;
			ac_bin <= 2'h0;
		end else begin
			ac_div <= ac_tick ? 8'h00 : ac_div + 8'h01;  // RULE1
			if (ac_tick)
				ac_bin <= ac_bin + 2'h1;  // RULE2
		end
	end

	// request decode
	wire [1:0]  wsel       = cpu_addr[3:2];
	wire        cpu_take   = (fsm == FS_IDLE) && cpu_valid && !cpu_ready;
	wire        rd_on_w    = !cpu_write && (st[hit_idx] == LS_WRITE);
	wire        vic_dirty  = dirty[vic_idx];
	wire        done_hit   = cpu_take && hit_any && !rd_on_w;
	wire        alloc_w    = cpu_take && !hit_any && !vic_dirty && cpu_write;
	wire        alloc_r    = cpu_take && !hit_any && !vic_dirty && !cpu_write;
	wire        need_wb    = cpu_take && !hit_any && vic_dirty;  // RULE10
	wire        fill_done  = (fsm == FS_RD_WAIT) && rd_out.valid;
	wire        touch      = done_hit || alloc_w || alloc_r || fill_done;  // RULE4 RULE5
	wire [IW-1:0] tgt_idx  = hit_any ? hit_idx : vic_idx;
	wire [IW-1:0] touch_idx = fill_done ? cur : tgt_idx;

	// background work runs only while no CPU access is being served
	wire        bg_ok      = (fsm == FS_IDLE) && !cpu_take;
	wire [3:0]  wb_limit   = flvl ? `LBA_WB_LIMIT1 : `LBA_WB_LIMIT0;
	wire        wb_room    = addr_in.ready && wdat_in.ready;  // RULE18
	wire        bg_flush   = bg_ok && flush_pend && fl_any;
	wire        flush_done = bg_ok && flush_pend && !fl_any;
	wire        bg_inv     = bg_ok && !flush_pend && inv_pend;  // RULE20
	wire        bg_exp     = bg_ok && !flush_pend && !inv_pend && ex_any;  // RULE6
	wire        ex_drop    = bg_exp && !dirty[ex_idx];  // RULE7
	wire        bg_lvl     = bg_ok && !flush_pend && !inv_pend && !ex_any
				&& (dirty_cnt > wb_limit);  // RULE25
	wire        wb_req     = (fsm == FS_WB) || bg_flush || (bg_exp && dirty[ex_idx]) || bg_lvl;
	wire [IW-1:0] wb_idx   = (fsm == FS_WB) ? cur : bg_flush ? fl_idx : bg_exp ? ex_idx : lvl_idx;
	wire        wb_go      = wb_req && wb_room;
	wire        wb_to_shared = (st[wb_idx] == LS_MODIFIED) && (bg_flush || bg_lvl);  // RULE19

	always_comb begin
		hit_any    = 1'b0;
		hit_idx    = '0;
		vic_idx    = '0;
		best       = '0;
		fl_any     = 1'b0;
		fl_idx     = '0;
		ex_any     = 1'b0;
		ex_idx     = '0;
		lvl_idx    = '0;
		lvl_best   = '0;
		dirty_cnt  = 4'h0;
		inv_avail  = 1'b0;
		shared_any = 1'b0;
		st_vec     = 16'h0000;
		for (int i = 0; i < NUM_LINES; i++) begin
			st_vec[2*i +: 2] = st[i];
			if (hit[i]) begin
				hit_any = 1'b1;
				hit_idx = IW'(i);
			end
			if (score[i] > best) begin  // RULE13 RULE24 RULE8
				best    = score[i];
				vic_idx = IW'(i);
			end
			if (dirty[i] && !fl_any) begin
				fl_any = 1'b1;
				fl_idx = IW'(i);
			end
			if (expd[i] && !ex_any) begin
				ex_any = 1'b1;
				ex_idx = IW'(i);
			end
			if (dirty[i] && ({1'b1, lru[i]} > lvl_best)) begin
				lvl_best = {1'b1, lru[i]};
				lvl_idx  = IW'(i);
			end
			if (dirty[i])
				dirty_cnt = dirty_cnt + 4'h1;
			if (line_en[i] && st[i] == LS_INVALID)
				inv_avail = 1'b1;
			if (st[i] == LS_SHARED)
				shared_any = 1'b1;
		end
	end

	// byte merge of a CPU write and of returning read data
	always_comb begin
		for (int b = 0; b < 16; b++) begin
			if ((b / 4 == int'(wsel)) && cpu_wstrb[b % 4]) begin
				mg_data[b*8 +: 8] = cpu_wdata[(b % 4)*8 +: 8];
				mg_be[b]          = 1'b1;
			end else begin
				mg_data[b*8 +: 8] = ldat[tgt_idx][b*8 +: 8];
				mg_be[b]          = hit_any && lbe[tgt_idx][b];
			end
			fill_data[b*8 +: 8] = lbe[cur][b] ? ldat[cur][b*8 +: 8] : rd_out.data[b*8 +: 8];
		end
	end

	for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
		wire [1:0] sbin = {stamp[i][1], ^stamp[i]};
		wire [1:0] age  = ac_bin - sbin;  // RULE26
		assign expd[i]  = (st[i] != LS_INVALID) && (age >= `LBA_AGE_LIMIT);  // RULE3
		assign dirty[i] = (st[i] == LS_WRITE) || (st[i] == LS_MODIFIED);
		assign hit[i]   = line_en[i] && (st[i] != LS_INVALID) && (tag[i] == cpu_addr[31:4]);
		assign score[i] = {line_en[i], st[i] == LS_INVALID, expd[i], st[i] == LS_SHARED,
				lru[i]};  // RULE27

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				st[i]    <= LS_INVALID;
				tag[i]   <= '0;
				ldat[i]  <= '0;
				lbe[i]   <= '0;
				lru[i]   <= '0;
				stamp[i] <= '0;
			end else begin
				if (touch && touch_idx == IW'(i)) begin
					lru[i]   <= '0;  // RULE11
					stamp[i] <= ac_gray;  // RULE4
				end else if (touch && lru[i] != '1) begin
					lru[i] <= lru[i] + 1'b1;  // RULE12
				end
				if (done_hit && cpu_write && hit_idx == IW'(i)) begin
					ldat[i] <= mg_data;
					lbe[i]  <= mg_be;
					if (st[i] == LS_SHARED || (&mg_be))
						st[i] <= LS_MODIFIED;
				end
				if ((alloc_w || alloc_r) && vic_idx == IW'(i)) begin
					tag[i]  <= cpu_addr[31:4];
					ldat[i] <= mg_data;
					lbe[i]  <= alloc_w ? mg_be : 16'h0000;
					st[i]   <= alloc_w ? LS_WRITE : LS_INVALID;
				end
				if (fill_done && cur == IW'(i)) begin
					ldat[i] <= fill_data;
					st[i]   <= (lbe[i] != 16'h0000) ? LS_MODIFIED : LS_SHARED;
				end
				if (wb_go && wb_idx == IW'(i)) begin
					st[i]  <= wb_to_shared ? LS_SHARED : LS_INVALID;  // RULE19
					lbe[i] <= 16'h0000;
				end
				if ((ex_drop && ex_idx == IW'(i)) || (bg_inv && st[i] == LS_SHARED))
					st[i] <= LS_INVALID;  // RULE7 RULE19
			end
		end
	end

	// access sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fsm       <= FS_IDLE;
			cur       <= '0;
			cpu_ready <= 1'b0;
			cpu_rdata <= 32'h0000_0000;
		end else begin
			cpu_ready <= done_hit || alloc_w || fill_done;
			if (done_hit)
				cpu_rdata <= ldat[hit_idx][{wsel, 5'h00} +: 32];
			else if (fill_done)
				cpu_rdata <= fill_data[{wsel, 5'h00} +: 32];
			case (fsm)
				FS_IDLE: begin
					if (need_wb) begin
						cur <= vic_idx;
						fsm <= FS_WB;
					end else if (alloc_r || (cpu_take && hit_any && rd_on_w)) begin
						cur <= tgt_idx;
						fsm <= FS_RD_REQ;
					end
				end
				FS_WB:      fsm <= wb_room ? FS_IDLE : FS_WB;  // RULE18
				FS_RD_REQ:  fsm <= addr_in.ready ? FS_RD_WAIT : FS_RD_REQ;
				FS_RD_WAIT: fsm <= rd_out.valid ? FS_IDLE : FS_RD_WAIT;
				default:    fsm <= FS_IDLE;
			endcase
		end
	end

	// outbound and inbound queues
	assign addr_in.valid  = wb_go || (fsm == FS_RD_REQ);
	assign addr_in.data   = wb_go ? {1'b1, tag[wb_idx], 4'h0} : {1'b0, tag[cur], 4'h0};
	assign wdat_in.valid  = wb_go;  // RULE17
	assign wdat_in.data   = {lbe[wb_idx], ldat[wb_idx]};
	assign addr_out.ready = m_addr_ready;
	assign wdat_out.ready = m_wdat_ready;
	assign m_addr_valid   = addr_out.valid;
	assign {m_addr_write, m_addr} = addr_out.data;
	assign m_wdat_valid   = wdat_out.valid;
	assign {m_wstb, m_wdat} = wdat_out.data;
	assign rd_in.valid    = s_rdat_valid;
	assign rd_in.data     = s_rdat;
	assign s_rdat_ready   = rd_in.ready;
	assign rd_out.ready   = (fsm == FS_RD_WAIT);
	assign br_in.valid    = s_bres_valid;
	assign br_in.data     = s_bres;
	assign s_bres_ready   = br_in.ready;
	assign br_out.ready   = 1'b1;

	// outbound queues face the AXI domain boundary
	lba_fifo #(.W(33), .DEPTH(OUT_DEPTH)) u_addr_q (  // RULE14 RULE16
		.aclk    (aclk),
		.aresetn (aresetn),
		.push_s  (addr_in),
		.pop_s   (addr_out)
	);
	lba_fifo #(.W(144), .DEPTH(OUT_DEPTH)) u_wdat_q (  // RULE14
		.aclk    (aclk),
		.aresetn (aresetn),
		.push_s  (wdat_in),
		.pop_s   (wdat_out)
	);
	lba_fifo #(.W(128), .DEPTH(IN_DEPTH)) u_rdat_q (  // RULE15
		.aclk    (aclk),
		.aresetn (aresetn),
		.push_s  (rd_in),
		.pop_s   (rd_out)
	);
	lba_fifo #(.W(2), .DEPTH(IN_DEPTH)) u_bres_q (  // RULE15
		.aclk    (aclk),
		.aresetn (aresetn),
		.push_s  (br_in),
		.pop_s   (br_out)
	);

	// register slave
	wire        wr_fire  = !s_awready && !s_wready && !s_bvalid;
	wire        wr_ctrl  = wr_fire && (aw_q == `LBA_OFF_CTRL);
	wire        wr_cmd   = wr_fire && (aw_q == `LBA_OFF_CMD) && ws_q[0];
	wire        wr_map   = (aw_q == `LBA_OFF_CTRL) || (aw_q == `LBA_OFF_CMD)
				|| (aw_q == `LBA_OFF_STATUS);
	wire        rd_map   = (s_araddr == `LBA_OFF_CTRL) || (s_araddr == `LBA_OFF_CMD)
				|| (s_araddr == `LBA_OFF_STATUS);
	wire [31:0] ctrl_rd  = {8'h00, 8'(line_en), 7'h00, flvl, period_cfg};
	wire [31:0] cmd_rd   = {30'h0, inv_pend, flush_pend};
	wire [31:0] stat_rd  = {9'h000, last_bresp, fsm != FS_IDLE || flush_pend || inv_pend,
				inv_pend, flush_pend, ac_gray, st_vec};
	wire [31:0] rd_mux   = (s_araddr == `LBA_OFF_CTRL) ? ctrl_rd :
				(s_araddr == `LBA_OFF_CMD) ? cmd_rd :
				(s_araddr == `LBA_OFF_STATUS) ? stat_rd : 32'h0000_0000;
	wire        set_fl   = sleep_entry || sideband_flush || (wr_cmd && w_q[`LBA_CMD_FLUSH_BIT]);
	wire        set_inv  = wr_cmd && w_q[`LBA_CMD_INV_BIT];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_awready  <= 1'b1;
			s_wready   <= 1'b1;
			s_bvalid   <= 1'b0;
			s_bresp    <= `LBA_RESP_OKAY;
			s_arready  <= 1'b1;
			s_rvalid   <= 1'b0;
			s_rdata    <= 32'h0000_0000;
			s_rresp    <= `LBA_RESP_OKAY;
			aw_q       <= 8'h00;
			w_q        <= 32'h0000_0000;
			ws_q       <= 4'h0;
			period_cfg <= `LBA_PERIOD_RST;
			flvl       <= `LBA_FLVL_RST;
			line_en    <= '1;
			flush_pend <= 1'b0;
			inv_pend   <= 1'b0;
			last_bresp <= `LBA_RESP_OKAY;
		end else begin
			if (s_awvalid && s_awready) begin
				s_awready <= 1'b0;
				aw_q      <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				s_wready <= 1'b0;
				w_q      <= s_wdata;
				ws_q     <= s_wstrb;
			end
			if (wr_fire) begin
				s_bvalid <= 1'b1;
				s_bresp  <= wr_map ? `LBA_RESP_OKAY : `LBA_RESP_SLVERR;
			end
			if (s_bvalid && s_bready) begin
				s_bvalid  <= 1'b0;
				s_awready <= 1'b1;
				s_wready  <= 1'b1;
			end
			if (wr_ctrl && ws_q[0])
				period_cfg <= w_q[7:0];
			if (wr_ctrl && ws_q[1])
				flvl <= w_q[`LBA_CTRL_FLVL_BIT];
			if (wr_ctrl && ws_q[2])
				line_en <= w_q[`LBA_CTRL_EN_LSB +: NUM_LINES];  // RULE27
			if (s_arvalid && s_arready) begin
				s_arready <= 1'b0;
				s_rvalid  <= 1'b1;
				s_rdata   <= rd_mux;
				s_rresp   <= rd_map ? `LBA_RESP_OKAY : `LBA_RESP_SLVERR;
			end
			if (s_rvalid && s_rready) begin
				s_rvalid  <= 1'b0;
				s_arready <= 1'b1;
			end
			flush_pend <= set_fl || (flush_pend && !flush_done);  // RULE9
			inv_pend   <= set_inv || (inv_pend && !bg_inv);
			if (br_out.valid)
				last_bresp <= br_out.data;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_aging_step: assert property ((ac_bin != $past(ac_bin)) |-> $past(ac_tick)
		&& ac_bin == $past(ac_bin) + 2'h1) else $error("aging counter step wrong"); // RULE1
	a_stale_drop: assert property (ex_drop |=> st[$past(ex_idx)] == LS_INVALID)
		else $error("stale shared line kept"); // RULE7
	a_touch_stamp: assert property (touch |=> stamp[$past(touch_idx)] == $past(ac_gray)
		&& lru[$past(touch_idx)] == '0) else $error("touch did not restamp"); // RULE4
	a_lru_other: assert property ((touch && touch_idx != '0 && lru[0] != '1)
		|=> lru[0] == $past(lru[0]) + 1'b1) else $error("lru not advanced"); // RULE12
	a_wb_paired: assert property ((wdat_in.valid && wdat_in.ready)
		|-> (addr_in.valid && addr_in.ready && addr_in.data[32])) else $error("data without addr"); // RULE17
	a_wb_taken: assert property ((fsm == FS_WB && wb_room) |=> fsm == FS_IDLE)
		else $error("flush not taken with room"); // RULE18
	a_flush_shared: assert property ((wb_go && wb_to_shared) |=> st[$past(wb_idx)] == LS_SHARED)
		else $error("flushed modified line not shared"); // RULE19
	a_inval_all: assert property (bg_inv |=> !shared_any)
		else $error("shared line survived invalidate"); // RULE19
	a_victim_inval: assert property ((cpu_take && !hit_any && inv_avail)
		|-> st[vic_idx] == LS_INVALID) else $error("invalid line not preferred"); // RULE24
	a_stale_first: assert property ((cpu_take && !hit_any && !inv_avail && |(expd & line_en))
		|-> expd[vic_idx]) else $error("stale line not preferred"); // RULE8

	c_read_fill: cover property (fill_done);
	c_age_flush: cover property (wb_go && bg_exp);
	c_barrier: cover property (flush_done ##[1:20] bg_inv);
	c_evict: cover property (fsm == FS_WB ##[1:8] fsm == FS_IDLE);
endmodule

// ---- lba_mem_model.sv ----
// far-side memory: answers line reads, counts write-backs
// assumes the unit's outbound and inbound streams on aclk
`timescale 1ns/100ps
module lba_mem_model (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         stall,
	input  wire logic         m_addr_valid,
	output logic              m_addr_ready,
	input  wire logic         m_addr_write,
	input  wire logic [31:0]  m_addr,
	input  wire logic         m_wdat_valid,
	output logic              m_wdat_ready,
	input  wire logic [127:0] m_wdat,
	input  wire logic [15:0]  m_wstb,
	output logic              s_rdat_valid,
	input  wire logic         s_rdat_ready,
	output logic [127:0]      s_rdat,
	output logic              s_bres_valid,
	input  wire logic         s_bres_ready,
	output logic [1:0]        s_bres,
	output logic [7:0]        wb_n,
	output logic [127:0]      wb_d,
	output logic [15:0]       wb_s
);
	logic [127:0] line;
	wire logic    take = m_addr_valid && m_addr_ready;
	// one transfer at a time; stall makes answers slow
	assign m_addr_ready = !stall && !s_rdat_valid && !s_bres_valid
		&& (!m_addr_write || m_wdat_valid);
	assign m_wdat_ready = take && m_addr_write;
	// released bus shows the inverse of the last line
	assign s_rdat = s_rdat_valid ? line : ~line;
	assign s_bres = 2'h0;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_rdat_valid <= 1'b0;
			s_bres_valid <= 1'b0;
			wb_n <= 8'h0;
		end else begin
			if (s_rdat_ready) s_rdat_valid <= 1'b0;
			if (s_bres_ready) s_bres_valid <= 1'b0;
			if (take && !m_addr_write) begin
				s_rdat_valid <= 1'b1;
				line <= {m_addr + 32'hc, m_addr + 32'h8, m_addr + 32'h4, m_addr};
			end
			if (take && m_addr_write) begin
				s_bres_valid <= 1'b1;
				wb_n <= wb_n + 8'h1;
				wb_d <= m_wdat;
				wb_s <= m_wstb;
			end
		end
	end
endmodule

// ---- tb_lba_data_line_buffer_unit.sv ----
// self-checking bench: register, cpu and memory traffic
// assumes lba_mem_model answers the outbound streams
`timescale 1ns/100ps
module tb_lba_data_line_buffer_unit;
	logic aclk = '0, aresetn = '0, s_awvalid = '0, s_wvalid = '0, s_bready = '0, s_arvalid = '0;
	logic s_rready = '0, cpu_valid = '0, cpu_write = '0, sleep_entry = '0, sideband_flush = '0;
	logic [7:0]   s_awaddr = '0, s_araddr = '0, wb_n;
	logic [31:0]  s_wdata = '0, cpu_addr = '0, cpu_wdata = '0, s_rdata, cpu_rdata, m_addr, rv;
	logic [3:0]   s_wstrb = 4'hf, cpu_wstrb = 4'hf, cyc = '0;
	logic [1:0]   s_bresp, s_rresp, s_bres, rr;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, cpu_ready, m_addr_valid, m_addr_ready;
	logic m_addr_write, m_wdat_valid, m_wdat_ready, s_rdat_valid, s_rdat_ready, s_bres_valid;
	logic s_bres_ready;
	logic [127:0] m_wdat, s_rdat, wb_d;
	logic [15:0]  m_wstb, wb_s;
	wire logic    stall = cyc[2];
	int           failures = 0, check_count = 0;
	lba_data_line_buffer_unit lba_data_line_buffer_unit_i (.*);
	lba_mem_model lba_mem_model_i (.*);
	always #12.5 aclk = ~aclk;
	always @(posedge aclk) cyc <= cyc + 4'h1;
	task automatic wrap_up();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic lim(input int n);
		if (n >= 60) begin
			failures++;
			wrap_up();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (s_awready) s_awvalid <= 1'b0;
			if (s_wready) s_wvalid <= 1'b0;
		end while (n < 60 && !s_bvalid);
		rr = s_bresp;
		s_bready <= 1'b0;
		lim(n);
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (s_arready) s_arvalid <= 1'b0;
		end while (n < 60 && !s_rvalid);
		rv = s_rdata;
		rr = s_rresp;
		s_rready <= 1'b0;
		lim(n);
	endtask
	task automatic cpu(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		cpu_write <= w;
		cpu_addr <= a;
		cpu_wdata <= d;
		cpu_valid <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (n < 60 && !cpu_ready);
		cpu_valid <= 1'b0;
		lim(n);
	endtask
	// polls line states until they settle and the sequencer is idle
	task automatic wst(input logic [7:0] e);
		int n;
		n = 0;
		do begin
			rd(8'h08);
			n++;
		end while (n < 60 && (rv[7:0] !== e || rv[20] !== 1'b0));
		chk("line_states", {24'h0, rv[7:0]}, {24'h0, e});
	endtask
	task automatic wwb(input logic [7:0] e);
		int n;
		for (n = 0; n < 40 && wb_n !== e; n++)
			@(posedge aclk);
		chk("writebacks", {24'h0, wb_n}, {24'h0, e});
	endtask
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h00);
		chk("ctrl", rv, 32'h000f0010);
		rd(8'h0c);
		chk("unmapped", {30'h0, rr}, 32'h00000002);
		wst(8'h00);
		wr(8'h00, 32'h000f00ff);
		chk("bresp", {30'h0, rr}, 32'h00000000);
		cpu(1'b0, 32'h00000100, '0);
		chk("miss_data", cpu_rdata, 32'h00000100);
		cpu(1'b0, 32'h00000108, '0);
		chk("hit_data", cpu_rdata, 32'h00000108);
		cpu(1'b1, 32'h00000204, 32'hcafe0001);
		wst(8'h09);
		wr(8'h04, 32'h00000001);
		wst(8'h01);
		wwb(8'h01);
		chk("wb_word", wb_d[63:32], 32'hcafe0001);
		chk("wb_strb", {16'h0, wb_s}, 32'h000000f0);
		wr(8'h04, 32'h00000002);
		wst(8'h00);
		for (int i = 0; i < 2; i++) begin
			cpu(1'b1, 32'h00000300, 32'h00000005);
			@(posedge aclk);
			sleep_entry <= (i == 0);
			sideband_flush <= (i == 1);
			@(posedge aclk);
			sleep_entry <= 1'b0;
			sideband_flush <= 1'b0;
			wst(8'h00);
		end
		wwb(8'h03);
		wr(8'h00, 32'h000f0001);
		cpu(1'b0, 32'h00000400, '0);
		cpu(1'b1, 32'h00000500, 32'h00000007);
		wst(8'h00);
		wwb(8'h04);
		wr(8'h00, 32'h000f00ff);
		cpu(1'b1, 32'h00000600, 32'h00000001);
		cpu(1'b1, 32'h00000700, 32'h00000002);
		cpu(1'b1, 32'h00000800, 32'h00000003);
		wwb(8'h05);
		wst(8'h82);
		cpu(1'b0, 32'h00000900, '0);
		cpu(1'b0, 32'h00000a00, '0);
		cpu(1'b0, 32'h00000b00, '0);
		chk("evict_data", cpu_rdata, 32'h00000b00);
		wst(8'h96);
		// only lines 0 and 3 enabled, both dirty: the miss must write back first
		wr(8'h00, 32'h000900ff);
		cpu(1'b0, 32'h00000c00, '0);
		chk("dirty_evict", cpu_rdata, 32'h00000c00);
		wwb(8'h06);
		wst(8'h56);
		wrap_up();
	end
endmodule
